// file: core/fmt_regs.svh
// constants of the output word formatter: offsets, fields, reset values, sequencing
`ifndef FMT_REGS_SVH
`define FMT_REGS_SVH

`define CTRL_OFFSET      12'h000
`define STATUS_OFFSET    12'h004
`define CTRL_MODE_LSB    0
`define CTRL_MODE_MSB    2
`define CTRL_HALF_BIT    3
`define CTRL_TAG_BIT     4
`define CTRL_RESET       5'h00
`define STAT_COUNT_LSB   0
`define STAT_ROT_LSB     4
`define STAT_PHASE_LSB   8
`define STAT_PEND_LSB    12
`define TAG_PREFIX       12'h800
`define QUEUE_DEPTH      6
`define CHAN_LAST        3'h5
`define MODE_ROTATE      3'h6
`define MODE_QUEUE       3'h7

`endif

// file: core/fmt_pkg.sv
// types shared by the output word formatter modules
package fmt_pkg;
  typedef logic [15:0] word_type;
  typedef logic [2:0]  chan_type;
  typedef struct packed {
    chan_type chan;
    word_type data;
  } entry_type;
  typedef struct packed {
    logic     valid;
    chan_type chan;
    word_type data;
  } item_type;
  typedef enum logic [1:0] {PH_0, PH_1, PH_2} phase_type;
endpackage : fmt_pkg

// file: core/queue_if.sv
// link between the formatter and its result queue
`timescale 1ns/100ps
interface queue_if;
  import fmt_pkg::*;
  logic      push;
  entry_type push_entry;
  logic      pop;
  entry_type head;
  logic [2:0] count;
  modport owner (output push, output push_entry, output pop, input head, input count);
  modport store (input push, input push_entry, input pop, output head, output count);
endinterface : queue_if

// file: core/result_queue.sv
// result queue: shift-down slots, oldest at slot 0
`timescale 1ns/100ps
`include "fmt_regs.svh"
module result_queue (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  queue_if.store    q
);
  import fmt_pkg::*;

  entry_type  slot_r [`QUEUE_DEPTH];
  logic [2:0] count_r;
  logic [2:0] count_nxt;
  logic [2:0] widx;
  wire        full   = (count_r == 3'(`QUEUE_DEPTH));
  wire        do_pop = q.pop && (count_r != 3'h0);
  wire        drop   = q.push && full && !do_pop;
  wire        shift  = do_pop || drop;

  assign widx = shift ? count_r - 3'h1 : count_r;
  assign count_nxt = drop ? count_r :
                     count_r + {2'b00, q.push} - {2'b00, do_pop};
  assign q.head  = slot_r[0];
  assign q.count = count_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_r <= 3'h0;
    end else begin
      count_r <= count_nxt;
    end
  end

  // reset empties the queue, so stale data never reads back as valid
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < `QUEUE_DEPTH; i++) slot_r[i] <= '0;
    end else begin
      for (int i = 0; i < `QUEUE_DEPTH; i++) begin
        if (q.push && widx == 3'(i)) begin
          slot_r[i] <= q.push_entry;
        end else if (shift && i < `QUEUE_DEPTH - 1) begin
          slot_r[i] <= slot_r[i+1];
        end
      end
    end
  end
endmodule : result_queue

// file: core/adc_output_word_formatter.sv
// output word formatter for the parallel read port, with apb control and status
`timescale 1ns/100ps
`include "fmt_regs.svh"
module adc_output_word_formatter (
  input  wire logic                clk_i,
  input  wire logic                rst_n_i,
  // apb slave
  input  wire logic                psel_i,
  input  wire logic                penable_i,
  input  wire logic                pwrite_i,
  input  wire logic [11:0]         paddr_i,
  input  wire logic [31:0]         pwdata_i,
  output logic      [31:0]         prdata_o,
  output logic                     pready_o,
  output logic                     pslverr_o,
  // per-channel result registers of the conversion core, same clock
  input  wire logic [5:0][15:0]    result_i,
  input  wire logic [5:0]          result_stb_i,
  // parallel read port pins
  input  wire logic                rd_n_i,
  input  wire logic                cs_n_i,
  output fmt_pkg::word_type        parallel_data_bus_o,
  output logic                     parallel_data_oe_n_o
);
  import fmt_pkg::*;

  queue_if qif ();

  result_queue u_queue (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .q       (qif.store)
  );

  function automatic chan_type next_chan(input chan_type c);
    next_chan = (c == `CHAN_LAST) ? 3'h0 : c + 3'h1;
  endfunction : next_chan

  function automatic logic is_tag_mode(input chan_type m, input logic tag_en);
    is_tag_mode = tag_en && (m == `MODE_ROTATE || m == `MODE_QUEUE);
  endfunction : is_tag_mode

  function automatic phase_type last_phase(input logic half, input logic tag);
    if (tag && half) last_phase = PH_2;
    else if (tag || half) last_phase = PH_1;
    else last_phase = PH_0;
  endfunction : last_phase

  function automatic word_type format_word(input item_type it, input logic half,
                                           input logic tag, input phase_type ph);
    word_type w;
    w = it.data;
    if (tag && !half) begin
      if (ph == PH_0) w = {`TAG_PREFIX, it.valid, it.chan};
    end else if (tag && half) begin
      case (ph)
        PH_0:    w = {2{it.valid, it.chan, it.data[3:0]}};
        PH_1:    w = {2{it.data[7:0]}};
        default: w = {2{it.data[15:8]}};
      endcase
    end else if (half) begin
      // byte placed on both lanes so either bus half may be wired
      w = (ph == PH_0) ? {2{it.data[7:0]}} : {2{it.data[15:8]}};
    end
    format_word = w;
  endfunction : format_word

  // configuration and sequencing state
  logic [4:0]  ctrl_r;
  logic        rd_s1_r, rd_s2_r, cs_s1_r, cs_s2_r;
  logic        act_d_r;
  phase_type   phase_r;
  phase_type   phase_nxt;
  chan_type    mode_r;
  logic        half_r;
  logic        tag_r;
  item_type    item_r;
  chan_type    rot_r;
  logic [5:0]  pend_r;
  logic [5:0]  fresh_r;
  word_type    data_r;

  // strobe: both pins synchronised before use
  wire         act_s     = !rd_s2_r && !cs_s2_r;
  wire         strobe_on = act_s && !act_d_r;
  wire         strobe_off = !act_s && act_d_r;

  wire chan_type  ctl_mode = ctrl_r[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
  wire            ctl_half = ctrl_r[`CTRL_HALF_BIT];
  wire            ctl_tag  = is_tag_mode(ctl_mode, ctrl_r[`CTRL_TAG_BIT]);
  wire            first    = (phase_r == PH_0);
  wire chan_type  sel_mode = first ? ctl_mode : mode_r;
  wire            sel_half = first ? ctl_half : half_r;
  wire            sel_tag  = first ? ctl_tag : tag_r;
  wire            q_valid  = (qif.count != 3'h0);
  wire chan_type  src_chan = (sel_mode == `MODE_QUEUE)  ? (q_valid ? qif.head.chan : 3'h0) :
                             (sel_mode == `MODE_ROTATE) ? rot_r : sel_mode;
  wire word_type  src_data = (sel_mode == `MODE_QUEUE)  ?
                             (q_valid ? qif.head.data : 16'h0000) :
                             result_i[src_chan];
  wire            src_valid = (sel_mode == `MODE_QUEUE) ? q_valid : fresh_r[src_chan];
  wire item_type  src_item = '{valid: src_valid, chan: src_chan, data: src_data};
  wire item_type  cur_item = first ? src_item : item_r;
  wire            item_end = strobe_off && (phase_r == last_phase(half_r, tag_r));

  assign phase_nxt = item_end ? PH_0 :
                     !strobe_off ? phase_r :
                     (phase_r == PH_0) ? PH_1 : PH_2;

  // results are queued only while rd and cs are not both low
  logic [5:0] push_onehot;
  chan_type   push_chan;
  always_comb begin
    push_onehot = 6'h00;
    push_chan   = 3'h0;
    for (int i = 5; i >= 0; i--) begin
      if (pend_r[i]) begin
        push_onehot = 6'h00;
        push_onehot[i] = 1'b1;
        push_chan = 3'(i);
      end
    end
  end
  assign qif.push       = (pend_r != 6'h00) && !act_s;
  assign qif.push_entry = '{chan: push_chan, data: result_i[push_chan]};
  assign qif.pop        = item_end && (mode_r == `MODE_QUEUE) && item_r.valid;

  wire [5:0] pend_clr  = qif.push ? push_onehot : 6'h00;
  wire [5:0] fresh_clr = (item_end && mode_r != `MODE_QUEUE && item_r.valid) ?
                         (6'h01 << item_r.chan) : 6'h00;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_s1_r <= 1'b1;
      rd_s2_r <= 1'b1;
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      act_d_r <= 1'b0;
    end else begin
      rd_s1_r <= rd_n_i;
      rd_s2_r <= rd_s1_r;
      cs_s1_r <= cs_n_i;
      cs_s2_r <= cs_s1_r;
      act_d_r <= act_s;
    end
  end

  // a result arriving as its flag clears still counts
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend_r  <= 6'h00;
      fresh_r <= 6'h00;
    end else begin
      pend_r  <= (pend_r & ~pend_clr) | result_stb_i;
      fresh_r <= (fresh_r & ~fresh_clr) | result_stb_i;
    end
  end

  // item settings frozen at its first strobe so a mid-item write cannot skew it
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_r <= 3'h0;
      half_r <= 1'b0;
      tag_r  <= 1'b0;
      item_r <= '0;
    end else if (strobe_on && first) begin
      mode_r <= ctl_mode;
      half_r <= ctl_half;
      tag_r  <= ctl_tag;
      item_r <= src_item;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_r <= PH_0;
      rot_r   <= 3'h0;
    end else begin
      phase_r <= phase_nxt;
      if (item_end && mode_r == `MODE_ROTATE) rot_r <= next_chan(rot_r);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_r <= 16'h0000;
    end else if (strobe_on) begin
      data_r <= format_word(cur_item, sel_half, sel_tag, phase_r);
    end
  end

  assign parallel_data_bus_o  = data_r;
  assign parallel_data_oe_n_o = !act_d_r;

  // apb: zero wait states, unmapped addresses answer with an error
  wire ctrl_hit = (paddr_i == `CTRL_OFFSET);
  wire stat_hit = (paddr_i == `STATUS_OFFSET);
  wire apb_wr   = psel_i && penable_i && pwrite_i && ctrl_hit;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_r <= `CTRL_RESET;
    end else if (apb_wr) begin
      ctrl_r <= pwdata_i[4:0];
    end
  end

  wire [31:0] status_word = (32'(qif.count) << `STAT_COUNT_LSB) |
                            (32'(rot_r) << `STAT_ROT_LSB) |
                            (32'(phase_r) << `STAT_PHASE_LSB) |
                            (32'(pend_r) << `STAT_PEND_LSB);

  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i && penable_i && !ctrl_hit && !stat_hit;
  assign prdata_o  = (psel_i && !pwrite_i && ctrl_hit) ? {27'h0, ctrl_r} :
                     (psel_i && !pwrite_i && stat_hit) ? status_word : 32'h0;
endmodule : adc_output_word_formatter

// file: dv/fmt_sva.sv
// assertions on the formatter's apb answers and read port pins
`timescale 1ns/100ps
module fmt_sva (
  input wire logic              clk_i,
  input wire logic              rst_n_i,
  input wire logic              psel_i,
  input wire logic              penable_i,
  input wire logic              pwrite_i,
  input wire logic [11:0]       paddr_i,
  input wire logic [31:0]       pwdata_i,
  input wire logic [31:0]       prdata_o,
  input wire logic              pready_o,
  input wire logic              pslverr_o,
  input wire logic              rd_n_i,
  input wire logic              cs_n_i,
  input wire fmt_pkg::word_type parallel_data_bus_o,
  input wire logic              parallel_data_oe_n_o
);
  import fmt_pkg::*;
  logic [4:0]  ctrl_r;
  wire         strb = !rd_n_i && !cs_n_i;
  wire         acc  = psel_i && penable_i;
  wire         umap = paddr_i != 12'h000 && paddr_i != 12'h004;
  wire         oe   = !parallel_data_oe_n_o;
  wire [15:0]  bus  = parallel_data_bus_o;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // shadow of the control word, needed to know when bytes must mirror
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) ctrl_r <= 5'h00;
    else if (acc && pwrite_i && paddr_i == 12'h000) ctrl_r <= pwdata_i[4:0];
  end
  AST_PREADY: assert property (pready_o) else $error("pready low");
  AST_SLVERR: assert property (acc |-> pslverr_o == umap) else $error("wrong pslverr");
  AST_UNMAP_RD: assert property (psel_i && umap |-> prdata_o == 32'h0)
    else $error("unmapped read not zero");
  AST_OE_ON: assert property (strb [*5] |-> oe) else $error("bus not driven");
  AST_OE_OFF: assert property (!strb [*5] |-> !oe) else $error("bus driven while idle");
  AST_HOLD: assert property (!strb [*4] |=> $stable(bus)) else $error("bus moved while idle");
  AST_HALF: assert property (ctrl_r[3] && oe [*2] |-> bus[15:8] == bus[7:0])
    else $error("byte not mirrored");
  AST_RST_IDLE: assert property ($rose(rst_n_i) |-> bus == 16'h0 && !oe)
    else $error("bus not idle after reset");
  cover property (acc && umap);
  cover property (ctrl_r == 5'h1f && oe);
  cover property (ctrl_r == 5'h16 && oe);
endmodule : fmt_sva
bind adc_output_word_formatter fmt_sva u_sva (.clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i,
  .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .rd_n_i, .cs_n_i,
  .parallel_data_bus_o, .parallel_data_oe_n_o);

// file: dv/host_reader.sv
// parallel bus host: strobes the read port and captures the bus
`timescale 1ns/100ps
module host_reader (
  input  wire logic              clk_i,
  input  wire fmt_pkg::word_type bus_i,
  output logic                   rd_n_o,
  output logic                   cs_n_o
);
  import fmt_pkg::*;
  initial begin
    rd_n_o = 1'b1;
    cs_n_o = 1'b1;
  end
  // slow hosts stretch lo_cyc; bus taken at the edge of release
  task automatic rd(input int lo_cyc, output word_type w);
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    rd_n_o <= 1'b0;
    repeat (lo_cyc) @(posedge clk_i);
    w = bus_i;
    rd_n_o <= 1'b1;
    cs_n_o <= 1'b1;
    repeat (6) @(posedge clk_i);
  endtask : rd
endmodule : host_reader

// file: dv/adc_output_word_formatter_tb_top.sv
// testbench of the output word formatter
`timescale 1ns/100ps
module adc_output_word_formatter_tb_top;
  import fmt_pkg::*;
  logic             clk_i = 1'b0, rst_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0;
  logic             pwrite_i = 1'b0, pready_o, pslverr_o, rd_n_i, cs_n_i, oe_n, err;
  logic [11:0]      paddr_i = 12'h000;
  logic [31:0]      pwdata_i = 32'h0, prdata_o, rdat;
  logic [5:0][15:0] result_i = 96'h0;
  logic [5:0]       result_stb_i = 6'h00;
  word_type         bus_o, w;
  int               miscompares = 0, n_checks = 0, seed = 40, cyc = 0;
  entry_type        q[$];
  always #10 clk_i = ~clk_i;
  adc_output_word_formatter DUT (.clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .result_i, .result_stb_i, .rd_n_i, .cs_n_i,
    .parallel_data_bus_o(bus_o), .parallel_data_oe_n_o(oe_n));
  host_reader u_host (.clk_i, .bus_i(bus_o), .rd_n_o(rd_n_i), .cs_n_o(cs_n_i));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      end_sim();
    end
  end
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rdat = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task automatic rst();
    rst_n_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    q.delete();
  endtask : rst
  task automatic rdk(output word_type r);
    u_host.rd(6 + ($random(seed) & 3), r);
  endtask : rdk
  // new results; the model drops its oldest entry once six are held
  task automatic post(input logic [5:0] m);
    logic [15:0] v;
    @(posedge clk_i);
    for (int c = 0; c < 6; c++) begin
      v = $random(seed);
      if (m[c]) begin
        result_i[c] <= v;
        if (q.size() == 6) void'(q.pop_front());
        q.push_back({3'(c), v});
      end
    end
    result_stb_i <= m;
    @(posedge clk_i);
    result_stb_i <= 6'h00;
    repeat (8) @(posedge clk_i);
  endtask : post
  function automatic word_type tagw(input logic v, input chan_type c);
    return {12'h800, v, c};
  endfunction : tagw
  function automatic word_type dup(input logic [7:0] b);
    return {b, b};
  endfunction : dup
  task automatic drain(input logic half);
    entry_type e;
    logic      v;
    word_type  f;
    for (int k = 0; k < 8; k++) begin
      v = q.size() != 0;
      e = v ? q.pop_front() : entry_type'(19'h0);
      rdk(f);
      if (half) begin
        chk(f, dup({v, e.chan, e.data[3:0]}));
        rdk(w);
        chk(w, dup(e.data[7:0]));
        rdk(w);
        chk(w, dup(e.data[15:8]));
      end else begin
        chk(f, tagw(v, e.chan));
        rdk(w);
        chk(w, e.data);
      end
      if (!(half ? f[7] : f[3])) break;
    end
  endtask : drain
  initial begin
    rst();
    apb(1'b0, 12'h000, 32'h0);
    chk(rdat, 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    chk({err, rdat}, 33'h100000000);
    apb(1'b1, 12'h004, 32'hff);
    apb(1'b0, 12'h004, 32'h0);
    chk({err, rdat}, 33'h0);
    for (int c = 0; c < 6; c++) begin
      post(6'h3f);
      apb(1'b1, 12'h000, 32'(c + 16 * (c % 2)));
      rdk(w);
      chk(w, result_i[c]);
      apb(1'b1, 12'h000, 32'(c + 8));
      rdk(w);
      chk(w, dup(result_i[c][7:0]));
      rdk(w);
      chk(w, dup(result_i[c][15:8]));
    end
    rst();
    post(6'h3f);
    apb(1'b1, 12'h000, 32'h16);
    for (int i = 0; i < 7; i++) begin
      rdk(w);
      chk(w, tagw(i < 6, 3'(i % 6)));
      rdk(w);
      chk(w, result_i[i % 6]);
    end
    apb(1'b1, 12'h000, 32'h6);
    rdk(w);
    chk(w, result_i[1]);
    rst();
    apb(1'b1, 12'h000, 32'h7);
    rdk(w);
    chk(w, 32'h0);
    // long strobe: the new result must still be pending mid-read
    fork
      u_host.rd(12, w);
      begin
        repeat (3) @(posedge clk_i);
        post(6'h10);
      end
      begin
        repeat (7) @(posedge clk_i);
        apb(1'b0, 12'h004, 32'h0);
        chk(rdat, 32'h0001_0000);
      end
    join
    chk(w, 32'h0);
    post(6'h0a);
    apb(1'b1, 12'h000, 32'h17);
    drain(1'b0);
    rst();
    post(6'h3f);
    post(6'h04);
    apb(1'b0, 12'h004, 32'h0);
    chk(rdat[2:0], 3'h6);
    apb(1'b1, 12'h000, 32'h1f);
    drain(1'b1);
    end_sim();
  end
endmodule : adc_output_word_formatter_tb_top
